/* File: core/pts_period_timer.sv */
`timescale 1ns/1ps
module pts_period_timer
	import pts_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	output logic                   irq,
	output logic                   pwm_time_base,
	output logic                   serial_shift_tick
);

	if (ADDR_W < 10 || ADDR_W > 16) begin : g_addr_w_check
		$error("pts_period_timer: ADDR_W must be 10 to 16");
	end

	typedef struct packed {
		pts_bus_e             bus;
		logic                 waitrequest;
		logic [31:0]          readdata;
		logic [1:0]           instr;
		logic [3:0]           pre;
		logic [3:0]           post;
		logic [7:0]           count;
		logic [7:0]           period;
		logic [PTS_CTL_W-1:0] ctl;
		logic                 flag;
		logic                 mask;
		logic                 irq;
		logic                 match;
	} pts_state_s;

	pts_state_s st_reg;
	pts_state_s st_next;

	logic [7:0] idx;
	logic       hit_ok;
	logic       wr_acc;
	logic       wr_byte;
	logic       wr_count;
	logic       wr_ctl;
	logic       wr_period;
	logic       wr_flag;
	logic       wr_mask;
	logic       instr_tick;
	logic       pre_tick;
	logic       cnt_match;
	logic       post_event;
	logic [1:0] pre_sel;
	logic [3:0] post_sel;
	logic [3:0] pre_last;

	assign idx        = address[PTS_IDX_SHIFT +: 8];
	// bits above the register map must be zero, else the access is acknowledged but ignored and reads return zero
	assign hit_ok     = (address[PTS_IDX_SHIFT-1:0] == 2'h0)
		&& ((address >> (PTS_IDX_SHIFT + 8)) == '0);
	assign wr_acc     = write && !st_reg.waitrequest;
	assign wr_byte    = wr_acc && hit_ok && byteenable[0];
	assign wr_count   = wr_byte && idx == PTS_IDX_COUNT;
	assign wr_ctl     = wr_byte && idx == PTS_IDX_CONTROL;
	assign wr_period  = wr_byte && idx == PTS_IDX_PERIOD;
	assign wr_flag    = wr_byte && idx == PTS_IDX_FLAG;
	assign wr_mask    = wr_byte && idx == PTS_IDX_MASK;
	assign pre_sel    = st_reg.ctl[PTS_CTL_PRE_MSB:PTS_CTL_PRE_LSB];
	assign post_sel   = st_reg.ctl[PTS_CTL_POST_MSB:PTS_CTL_POST_LSB];
	assign pre_last   = pts_pre_last(pre_sel);
	assign instr_tick = st_reg.instr == PTS_INSTR_LAST;
	assign pre_tick   = st_reg.ctl[PTS_CTL_RUN_BIT] && instr_tick && st_reg.pre >= pre_last;
	assign cnt_match  = pre_tick && st_reg.count == st_reg.period;
	assign post_event = cnt_match && st_reg.post == post_sel;

	always_comb begin
		st_next       = st_reg;
		st_next.match = 1'b0;
		// quarter counter runs free; writes never realign the instruction phase
		st_next.instr = st_reg.instr + 2'h1;

		// bus slave: one wait cycle, then a single accept cycle
		case (st_reg.bus)
			PTS_BUS_IDLE: begin
				if (read || write) begin
					st_next.bus         = PTS_BUS_ACK;
					st_next.waitrequest = 1'b0;
					st_next.readdata    = 32'h0000_0000;
					if (read && hit_ok) begin
						case (idx)
							PTS_IDX_COUNT:   st_next.readdata[7:0] = st_reg.count;
							PTS_IDX_PERIOD:  st_next.readdata[7:0] = st_reg.period;
							PTS_IDX_CONTROL: st_next.readdata[PTS_CTL_W-1:0] = st_reg.ctl;
							PTS_IDX_FLAG:    st_next.readdata[PTS_FLAG_MATCH_BIT] = st_reg.flag;
							PTS_IDX_MASK:    st_next.readdata[PTS_FLAG_MATCH_BIT] = st_reg.mask;
							default:         st_next.readdata = 32'h0000_0000;
						endcase
					end
				end
			end
			PTS_BUS_ACK: begin
				st_next.bus         = PTS_BUS_IDLE;
				st_next.waitrequest = 1'b1;
			end
			default: begin
				st_next.bus         = PTS_BUS_IDLE;
				st_next.waitrequest = 1'b1;
			end
		endcase

		if (st_reg.ctl[PTS_CTL_RUN_BIT] && instr_tick) begin
			st_next.pre = pre_tick ? 4'h0 : st_reg.pre + 4'h1;
		end

		// count up, return to zero after match
		if (pre_tick) begin
			st_next.count = cnt_match ? PTS_COUNT_RST : st_reg.count + 8'h01;
		end

		if (cnt_match) begin
			st_next.match = 1'b1;
			st_next.post  = post_event ? 4'h0 : st_reg.post + 4'h1;
		end

		if (wr_count) begin
			st_next.count = writedata[7:0];
		end
		if (wr_period) begin
			st_next.period = writedata[7:0];
		end
		if (wr_ctl) begin
			st_next.ctl = writedata[PTS_CTL_W-1:0];
		end
		if (wr_mask) begin
			st_next.mask = writedata[PTS_FLAG_MATCH_BIT];
		end

		if (wr_count || wr_ctl) begin
			st_next.pre  = 4'h0;
			st_next.post = 4'h0;
		end

		if (wr_flag && !writedata[PTS_FLAG_MATCH_BIT]) begin
			st_next.flag = 1'b0;
		end
		if (post_event) begin
			st_next.flag = 1'b1;
		end

		st_next.irq = st_next.flag && st_next.mask;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg             <= '0;
			st_reg.bus         <= PTS_BUS_IDLE;
			st_reg.waitrequest <= 1'b1;
			st_reg.count       <= PTS_COUNT_RST;
			st_reg.period      <= PTS_PERIOD_RST;
			st_reg.ctl         <= PTS_CTL_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign readdata          = st_reg.readdata;
	assign waitrequest       = st_reg.waitrequest;
	assign irq               = st_reg.irq;
	assign pwm_time_base     = st_reg.match;
	assign serial_shift_tick = st_reg.match;

	// assertions
	sequence s_req;
		(read || write) && st_reg.waitrequest;
	endsequence

	sequence s_count_wr;
		wr_count;
	endsequence

	sequence s_scaler_wr;
		wr_count || wr_ctl;
	endsequence

	sequence s_wrap;
		cnt_match && !wr_count;
	endsequence

	sequence s_period_wr;
		wr_period;
	endsequence

	sequence s_ctl_wr;
		wr_ctl;
	endsequence

	sequence s_flag_clear;
		wr_flag && !writedata[PTS_FLAG_MATCH_BIT] && !post_event;
	endsequence

	sequence s_step;
		pre_tick && !cnt_match && !wr_count;
	endsequence

	sequence s_post_wrap;
		post_event && !wr_count && !wr_ctl;
	endsequence

	sequence s_pre_step;
		st_reg.ctl[PTS_CTL_RUN_BIT] && instr_tick && !pre_tick && !wr_count && !wr_ctl;
	endsequence

	AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
		s_req |-> ##[1:2] !waitrequest)
		else $error("bus request not answered in two cycles");

	AST_COUNT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		s_count_wr |=> st_reg.count == $past(writedata[7:0]))
		else $error("counter write not stored");

	AST_PRESCALE_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.pre <= pts_pre_last(st_reg.ctl[PTS_CTL_PRE_MSB:PTS_CTL_PRE_LSB])
		|| $past(wr_ctl))
		else $error("prescaler beyond its terminal count");

	AST_POST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_match && !post_event && !wr_count && !wr_ctl
		|=> st_reg.post == $past(st_reg.post) + 4'h1)
		else $error("postscaler did not advance on match");

	AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
		post_event |=> st_reg.flag && (st_reg.irq == st_reg.mask))
		else $error("postscaler event did not set flag");

	AST_SCALER_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		s_scaler_wr |=> st_reg.pre == 4'h0 && st_reg.post == 4'h0)
		else $error("scalers not cleared by write");

	AST_CTRL_KEEPS_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctl && !pre_tick |=> $stable(st_reg.count))
		else $error("control write changed the counter");

	AST_STOPPED: assert property (@(posedge clk) disable iff (!rst_n)
		!st_reg.ctl[PTS_CTL_RUN_BIT] && !wr_count |=> $stable(st_reg.count) && !pwm_time_base)
		else $error("stopped timer moved");

	AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		s_wrap |=> st_reg.count == PTS_COUNT_RST && pwm_time_base && serial_shift_tick)
		else $error("counter did not wrap at period");

	AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.flag && !wr_flag |=> st_reg.flag)
		else $error("flag dropped without software clear");

	AST_PERIOD_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		s_period_wr |=> st_reg.period == $past(writedata[7:0]))
		else $error("period write not stored");

	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctl_wr |=> st_reg.ctl == $past(writedata[PTS_CTL_W-1:0]))
		else $error("control write not stored");

	AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		s_flag_clear |=> !st_reg.flag)
		else $error("flag not cleared by writing zero");

	AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		s_step |=> st_reg.count == $past(st_reg.count) + 8'h01)
		else $error("counter did not step on prescaler tick");

	AST_POST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		s_post_wrap |=> st_reg.post == 4'h0 && st_reg.flag)
		else $error("postscaler did not wrap on its event");

	AST_PRESCALE_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		s_pre_step |=> st_reg.pre == $past(st_reg.pre) + 4'h1)
		else $error("prescaler did not advance on instruction tick");

	AST_PRESCALE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_tick && !wr_count && !wr_ctl |=> $stable(st_reg.pre))
		else $error("prescaler moved between instruction ticks");

	AST_PULSE_ONE: assert property (@(posedge clk) disable iff (!rst_n)
		pwm_time_base |=> !pwm_time_base)
		else $error("time base pulse longer than one cycle");

	AST_PULSE_NEEDS_RUN: assert property (@(posedge clk) disable iff (!rst_n)
		pwm_time_base |-> $past(st_reg.ctl[PTS_CTL_RUN_BIT]))
		else $error("match pulse while timer stopped");

	AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!rst_n)
		!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");

	AST_READ_HIGH_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		!waitrequest |-> readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	AST_CTRL_BIT7: assert property (@(posedge clk) disable iff (!rst_n)
		!waitrequest && read && idx == PTS_IDX_CONTROL |-> !readdata[PTS_CTL_W])
		else $error("control top bit read as one");

	AST_NO_WRAP_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
		pre_tick && st_reg.count != st_reg.period |=> !pwm_time_base)
		else $error("match pulse before count reached period");

	AST_FLAG_ONLY_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
		!st_reg.flag && !post_event |=> !st_reg.flag)
		else $error("flag set without postscaler event");

	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wr_mask |=> st_reg.mask == $past(writedata[PTS_FLAG_MATCH_BIT]))
		else $error("mask write not stored");

endmodule

/* File: core/pts_pkg.sv */
package pts_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] PTS_IDX_FLAG    = 8'h0c;
	localparam logic [7:0] PTS_IDX_COUNT   = 8'h11;
	localparam logic [7:0] PTS_IDX_CONTROL = 8'h12;
	localparam logic [7:0] PTS_IDX_MASK    = 8'h8c;
	localparam logic [7:0] PTS_IDX_PERIOD  = 8'h92;
	localparam int         PTS_IDX_SHIFT   = 2;

	// control register layout
	localparam int PTS_CTL_W        = 7;
	localparam int PTS_CTL_PRE_LSB  = 0;
	localparam int PTS_CTL_PRE_MSB  = 1;
	localparam int PTS_CTL_RUN_BIT  = 2;
	localparam int PTS_CTL_POST_LSB = 3;
	localparam int PTS_CTL_POST_MSB = 6;

	// flag and mask register layout
	localparam int PTS_FLAG_MATCH_BIT = 1;

	// reset values
	localparam logic [7:0]           PTS_COUNT_RST  = 8'h00;
	localparam logic [7:0]           PTS_PERIOD_RST = 8'hff;
	localparam logic [PTS_CTL_W-1:0] PTS_CTL_RST    = 7'h00;

	// instruction clock is the system clock divided by four
	localparam logic [1:0] PTS_INSTR_LAST = 2'h3;

	// prescale terminal counts for 1, 4 and 16
	localparam logic [3:0] PTS_PRE_LAST_1  = 4'h0;
	localparam logic [3:0] PTS_PRE_LAST_4  = 4'h3;
	localparam logic [3:0] PTS_PRE_LAST_16 = 4'hf;

	typedef enum logic [0:0] {
		PTS_BUS_IDLE = 1'b0,
		PTS_BUS_ACK  = 1'b1
	} pts_bus_e;

	function automatic logic [3:0] pts_pre_last(input logic [1:0] sel);
		case (sel)
			2'h0:    pts_pre_last = PTS_PRE_LAST_1;
			2'h1:    pts_pre_last = PTS_PRE_LAST_4;
			default: pts_pre_last = PTS_PRE_LAST_16;
		endcase
	endfunction

endpackage

/* File: verification/pts_period_timer_tb.sv */
`timescale 1ns/1ps
module pts_period_timer_tb;
	import pts_pkg::*;
	logic        clk;
	logic        rst_n;
	logic [9:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        irq;
	logic        pwm_time_base;
	logic        serial_shift_tick;
	int          n_mismatch;
	int          comparisons;
	logic [31:0] q;
	int          per;
	int          cnt;
	int          gap;
	int          ticks;

	pts_period_timer #(.ADDR_W(10)) u_pts_period_timer (
		.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .pwm_time_base(pwm_time_base),
		.serial_shift_tick(serial_shift_tick));

	always #2.5 clk = ~clk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// the request stands until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		address   <= {idx, 2'b00};
		write     <= wr;
		read      <= !wr;
		writedata <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	// clocks between matches: four per instruction tick, times prescale, times period plus one
	function automatic int exp_gap(input int code, input int per);
		exp_gap = 4 * (code[1] ? 16 : (code[0] ? 4 : 1)) * (per + 1);
	endfunction

	task rd(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(q, exp);
	endtask

	// pulses are sampled at edges, so gap counts whole clocks
	task wait_pulse;
		gap = 0;
		do begin
			@(posedge clk);
			gap++;
		end while (pwm_time_base !== 1'b1 && gap < 2000);
	endtask

	// serial tick is the pre-postscaler match
	always @(posedge clk)
		if (rst_n) check(serial_shift_tick, pwm_time_base);

	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		clk = 0; rst_n = 0; address = '0; read = 0; write = 0;
		writedata = '0; byteenable = 4'h1;
		void'($urandom(35353));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(PTS_IDX_COUNT, 8'h00);
		rd(PTS_IDX_PERIOD, 8'hff);
		rd(PTS_IDX_CONTROL, 8'h00);
		rd(PTS_IDX_FLAG, 8'h00);
		rd(PTS_IDX_MASK, 8'h00);
		bus(1'b1, 8'h01, 8'h5a);
		rd(8'h01, 8'h00);
		bus(1'b1, PTS_IDX_CONTROL, 8'hff);
		rd(PTS_IDX_CONTROL, 8'h7f);
		bus(1'b1, PTS_IDX_CONTROL, 8'h00);
		bus(1'b1, PTS_IDX_COUNT, 8'h5a);
		byteenable <= 4'h0;
		bus(1'b1, PTS_IDX_COUNT, 8'h11);
		byteenable <= 4'h1;
		repeat (40) @(posedge clk);
		rd(PTS_IDX_COUNT, 8'h5a);
		bus(1'b1, PTS_IDX_CONTROL, 8'h78);
		rd(PTS_IDX_COUNT, 8'h5a);
		// every prescale code, random period, corner period zero first
		for (int i = 0; i < 8; i++) begin
			per = (i == 0) ? 0 : $urandom_range(7);
			bus(1'b1, PTS_IDX_CONTROL, 8'h00);
			bus(1'b1, PTS_IDX_COUNT, 8'h00);
			bus(1'b1, PTS_IDX_PERIOD, per[7:0]);
			rd(PTS_IDX_PERIOD, per[7:0]);
			bus(1'b1, PTS_IDX_CONTROL, {5'h00, 1'b1, i[1:0]});
			wait_pulse();
			wait_pulse();
			check(gap, exp_gap(i, per));
		end
		bus(1'b1, PTS_IDX_PERIOD, 8'h03);
		bus(1'b1, PTS_IDX_MASK, 8'h02);
		// the control write clears the postscaler, so it starts from zero
		for (int n = 0; n < 16; n++) begin
			bus(1'b1, PTS_IDX_CONTROL, 8'h00);
			bus(1'b1, PTS_IDX_FLAG, 8'h00);
			bus(1'b1, PTS_IDX_CONTROL, {1'b0, n[3:0], 3'h4});
			cnt = 0;
			ticks = 0;
			gap = 0;
			// irq rises together with the pulse of the last counted match
			while (irq !== 1'b1 && gap < 1000) begin
				@(posedge clk);
				gap++;
				if (pwm_time_base === 1'b1) cnt++;
				if (serial_shift_tick === 1'b1) ticks++;
			end
			check(cnt, n + 1);
			check(ticks, n + 1);
		end
		bus(1'b1, PTS_IDX_MASK, 8'h00);
		bus(1'b1, PTS_IDX_CONTROL, 8'h00);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		bus(1'b1, PTS_IDX_FLAG, 8'h02);
		rd(PTS_IDX_FLAG, 8'h02);
		bus(1'b1, PTS_IDX_MASK, 8'h02);
		repeat (2) @(posedge clk);
		check(irq, 1'b1);
		bus(1'b1, PTS_IDX_FLAG, 8'h00);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		rd(PTS_IDX_FLAG, 8'h00);
		bus(1'b1, PTS_IDX_COUNT, 8'h33);
		bus(1'b1, PTS_IDX_PERIOD, 8'h44);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(PTS_IDX_COUNT, 8'h00);
		rd(PTS_IDX_PERIOD, 8'hff);
		report_and_stop();
	end
endmodule
